// [rtl/ocos_pkg.sv]
/*
  Package for the overcurrent / overload sequencer: timing constants,
  state enumeration and the grouped comparator and drive structs.
  Assumes a 50 MHz system clock.
*/
package ocos_pkg;

  // Clock rate in kHz and pulse times in ns
  localparam int unsigned CLK_KHZ = 50000;
  localparam int unsigned SS_PULSE_NS = 5000;
  localparam int unsigned TIMER_PULSE_NS = 50000;

  // Least times round up to whole cycles
  localparam int unsigned SS_PULSE_CYC =
    (SS_PULSE_NS * (CLK_KHZ / 1000) + 999) / 1000;
  localparam int unsigned TIMER_PULSE_CYC =
    (TIMER_PULSE_NS * (CLK_KHZ / 1000) + 999) / 1000;
  localparam int unsigned CNT_W = 12;

  // Overload handling states
  typedef enum logic [2:0] {
    OCOS_NORMAL,
    OCOS_SHUTDOWN,
    OCOS_STOPPED,
    OCOS_RESTART
  } ocos_state_t;

  // Analog comparator outputs, high when the input is above the level
  typedef struct packed {
    logic sense_above_limit;   // Tank current sense above first level
    logic sense_above_trip;    // Tank current sense above second level
    logic timer_above_shut;    // Timer node above shutdown threshold
    logic timer_above_stop;    // Timer node above stop threshold
    logic timer_above_restart; // Timer node above restart threshold
  } ocos_cmp_t;

  // Drives toward the power stage
  typedef struct packed {
    logic ss_discharge;   // Soft-start discharge switch closed
    logic timer_source;   // Timer current source on
    logic switch_enable;  // Half-bridge switching allowed
    logic near_start;     // Run near soft-start starting frequency
  } ocos_drive_t;

endpackage : ocos_pkg

// [rtl/ocos_pulse.sv]
/*
  Retriggerable one-shot: output high for LEN cycles after the last
  trigger. Trigger comes from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module ocos_pulse #(
  parameter int unsigned LEN = 250,
  parameter int unsigned W = 12
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic trigger_i,
  output logic active_o
);

  logic [W-1:0] count;

  // Reload on every trigger, then count down
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count <= '0;
    end else if (trigger_i) begin
      count <= W'(LEN);
    end else if (count != '0) begin
      count <= count - W'(1);
    end
  end

  assign active_o = (count != '0);

endmodule // ocos_pulse

`default_nettype wire

// [rtl/ocos_seq.sv]
/*
  Overcurrent and overload protection sequencer: turns comparator levels
  into soft-start discharge, timer current source, switching enable and
  the open-drain preregulator halt drive.
  Assumes asynchronous comparator inputs and one 50 MHz clock.
*/
// Function
// - Sense above first level starts overcurrent response
// - Each event closes discharge switch 5 us
// - Each event enables timer source 50 us
// - Both pulses retrigger on every new event
// - Below shutdown threshold only pulses act
// - At shutdown threshold: discharge, halt, source on
// - Shutdown phase runs near soft-start frequency
// - At stop threshold stop switching, source off
// - Restart only below restart threshold
// - Undervoltage during stop wait is remembered
// - Halt low from shutdown until timer falls below restart
// - Second level stops switching, both held on
// - Second-level trip latch releases at restart
// - Halt open-drain, released by default and UVLO
`timescale 1ns/1ps
`default_nettype none

module ocos_seq #(
  parameter int unsigned SS_CYC = ocos_pkg::SS_PULSE_CYC,
  parameter int unsigned TIMER_CYC = ocos_pkg::TIMER_PULSE_CYC
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire ocos_pkg::ocos_cmp_t cmp_i,
  input wire logic uvlo_i,
  output ocos_pkg::ocos_drive_t drive_o,
  output logic preregulator_halt_o,
  output logic preregulator_halt_oe_o,
  output logic [2:0] state_o
);

  logic [4:0] cmp_meta;
  logic [4:0] cmp_sync;
  logic uvlo_meta;
  logic uvlo_sync;
  logic limit_prev;
  logic limit_event;
  logic ss_pulse;
  logic timer_pulse;
  logic hard_trip;
  logic uvlo_seen;
  ocos_pkg::ocos_cmp_t c;
  ocos_pkg::ocos_state_t state;
  ocos_pkg::ocos_state_t next_state;
  ocos_pkg::ocos_drive_t next_drive;
  logic next_halt;

  // Two-stage synchronisers for all comparator levels
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmp_meta <= '0;
      cmp_sync <= '0;
      uvlo_meta <= 1'b1;
      uvlo_sync <= 1'b1;
    end else begin
      cmp_meta <= cmp_i;
      cmp_sync <= cmp_meta;
      uvlo_meta <= uvlo_i;
      uvlo_sync <= uvlo_meta;
    end
  end

  assign c = cmp_sync;

  // Rising edge of the first-level comparator is one event
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      limit_prev <= 1'b0;
    end else begin
      limit_prev <= c.sense_above_limit;
    end
  end

  assign limit_event = c.sense_above_limit && !limit_prev;

  // Retriggerable discharge pulse
  ocos_pulse #(.LEN(SS_CYC), .W(ocos_pkg::CNT_W)) u_ss_pulse (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .trigger_i(limit_event && !uvlo_sync),
    .active_o(ss_pulse)
  );

  // Retriggerable timer charge pulse
  ocos_pulse #(.LEN(TIMER_CYC), .W(ocos_pkg::CNT_W)) u_timer_pulse (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .trigger_i(limit_event && !uvlo_sync),
    .active_o(timer_pulse)
  );

  // Second-level trip latch, cleared once the wait has ended
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hard_trip <= 1'b0;
    end else if (c.sense_above_trip && !uvlo_sync) begin
      hard_trip <= 1'b1;
    end else if (state == ocos_pkg::OCOS_RESTART) begin
      hard_trip <= 1'b0;
    end
  end

  // Undervoltage during the stop wait is remembered; set wins
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      uvlo_seen <= 1'b0;
    end else if (uvlo_sync && state == ocos_pkg::OCOS_STOPPED) begin
      uvlo_seen <= 1'b1;
    end else if (!c.timer_above_restart) begin
      uvlo_seen <= 1'b0;
    end
  end

  // Overload state sequencing
  always_comb begin
    next_state = state;
    case (state)
      ocos_pkg::OCOS_NORMAL: begin
        if (hard_trip || (c.sense_above_trip && !uvlo_sync)) begin
          next_state = ocos_pkg::OCOS_SHUTDOWN;
        end else if (c.timer_above_shut) begin
          next_state = ocos_pkg::OCOS_SHUTDOWN;
        end
      end
      ocos_pkg::OCOS_SHUTDOWN: begin
        if (c.timer_above_stop) begin
          next_state = ocos_pkg::OCOS_STOPPED;
        end
      end
      ocos_pkg::OCOS_STOPPED: begin
        if (!c.timer_above_restart) begin
          next_state = ocos_pkg::OCOS_RESTART;
        end
      end
      ocos_pkg::OCOS_RESTART: begin
        if (c.timer_above_restart) begin
          next_state = ocos_pkg::OCOS_STOPPED;
        end else if (!uvlo_sync && !uvlo_seen) begin
          next_state = ocos_pkg::OCOS_NORMAL;
        end
      end
      default: next_state = ocos_pkg::OCOS_NORMAL;
    endcase
  end

  // State register
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= ocos_pkg::OCOS_NORMAL;
    end else begin
      state <= next_state;
    end
  end

  // Drive decode from state and pulses
  always_comb begin
    next_drive = '0;
    next_halt = 1'b0;
    case (state)
      ocos_pkg::OCOS_NORMAL: begin
        next_drive.ss_discharge = ss_pulse;
        next_drive.timer_source = timer_pulse;
        next_drive.switch_enable = !uvlo_sync;
      end
      ocos_pkg::OCOS_SHUTDOWN: begin
        next_drive.ss_discharge = 1'b1;
        next_drive.timer_source = 1'b1;
        next_drive.switch_enable = !hard_trip && !uvlo_sync;
        next_drive.near_start = !hard_trip;
        next_halt = 1'b1;
      end
      ocos_pkg::OCOS_STOPPED: begin
        next_drive.ss_discharge = 1'b1;
        next_halt = 1'b1;
      end
      ocos_pkg::OCOS_RESTART: begin
        next_drive.ss_discharge = 1'b1;
        next_halt = c.timer_above_restart;
      end
      default: begin
        next_drive = '0;
      end
    endcase
    if (uvlo_sync) begin
      next_halt = 1'b0;
    end
  end

  // Registered outputs; halt pin only ever pulls low
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      drive_o <= '0;
      preregulator_halt_oe_o <= 1'b0;
      preregulator_halt_o <= 1'b0;
      state_o <= 3'h0;
    end else begin
      drive_o <= next_drive;
      preregulator_halt_oe_o <= next_halt;
      preregulator_halt_o <= 1'b0;
      state_o <= next_state;
    end
  end

endmodule // ocos_seq

`default_nettype wire

// [sim/ocos_seq_monitor.sv]
/* Port checker for ocos_seq.
   Assumes a bind to ocos_seq and one clock. */
`timescale 1ns/1ps
`default_nettype none
module ocos_seq_monitor (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire ocos_pkg::ocos_cmp_t cmp_i,
  input wire logic uvlo_i,
  input wire ocos_pkg::ocos_drive_t drive_o,
  input wire logic preregulator_halt_o,
  input wire logic preregulator_halt_oe_o,
  input wire logic [2:0] state_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // Settled supply, then a first or second level event in normal state
  sequence s_up;
    (!uvlo_i)[*3];
  endsequence
  sequence s_lim;
    s_up ##0 ($rose(cmp_i.sense_above_limit) && state_o == 3'h0);
  endsequence
  sequence s_trip;
    s_up ##0 ($rose(cmp_i.sense_above_trip) && state_o == 3'h0);
  endsequence
  AST_EVENT_PULSES: assert property (s_lim |-> ##[4:5]
    (drive_o.ss_discharge && drive_o.timer_source)) else $error("no pulses");
  AST_TRIP_STOP: assert property (s_trip |-> ##[4:5]
    (!drive_o.switch_enable && drive_o.ss_discharge && drive_o.timer_source))
    else $error("trip not handled");
  AST_SHUT_HOLD: assert property ((state_o == 3'h1 && !uvlo_i)[*4] |->
    drive_o.ss_discharge && drive_o.timer_source && preregulator_halt_oe_o)
    else $error("shutdown drives wrong");
  AST_STOP_QUIET: assert property ((state_o == 3'h2)[*2] |->
    !drive_o.switch_enable && !drive_o.timer_source) else $error("not stopped");
  AST_NO_EARLY: assert property ((state_o == 3'h2 &&
    cmp_i.timer_above_restart)[*3] |=> state_o == 3'h2)
    else $error("early restart");
  AST_HALT_HELD: assert property ((state_o == 3'h2 && !uvlo_i)[*4] |->
    preregulator_halt_oe_o) else $error("halt released early");
  AST_UVLO_REL: assert property (uvlo_i[*4] |=> !preregulator_halt_oe_o)
    else $error("halt driven in undervoltage");
  AST_NORMAL_RUN: assert property ((state_o == 3'h0 && !uvlo_i)[*5] |->
    drive_o.switch_enable && !preregulator_halt_oe_o && !preregulator_halt_o)
    else $error("normal run wrong");
endmodule // ocos_seq_monitor
bind ocos_seq ocos_seq_monitor ocos_seq_monitor_i (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .cmp_i(cmp_i), .uvlo_i(uvlo_i),
  .drive_o(drive_o), .preregulator_halt_o(preregulator_halt_o),
  .preregulator_halt_oe_o(preregulator_halt_oe_o), .state_o(state_o));
`default_nettype wire

// [sim/ocos_tank_model.sv]
/* Timer node model: charges while the source is on, leaks otherwise, held at zero while grounded.
   Assumes the sequencer drive on the same clock. */
`timescale 1ns/1ps
`default_nettype none
module ocos_tank_model #(
  parameter int SHUT = 30,
  parameter int STOP = 50,
  parameter int RESTART = 5
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire ocos_pkg::ocos_drive_t drive_i,
  input wire logic grounded_i,
  output logic [2:0] timer_cmp_o
);
  int level;
  // Capacitor level; a grounded pin never charges
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) level <= 0;
    else if (grounded_i) level <= 0;
    else if (drive_i.timer_source) level <= level + 1;
    else if (level > 0) level <= level - 1;
  end
  // Threshold comparators: shutdown, stop, restart
  assign timer_cmp_o = {level >= SHUT, level >= STOP, level > RESTART};
endmodule // ocos_tank_model
`default_nettype wire

// [sim/tb_ocos_seq.sv]
/* Self-checking bench for ocos_seq with a timer node model.
   Assumes short pulse parameters 3 and 10 cycles. */
`timescale 1ns/1ps
`default_nettype none
module tb_ocos_seq;
  typedef struct packed {logic [7:0] k; logic [1:0] e;} ocos_row_t;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic limit = 1'b0;
  logic trip = 1'b0;
  logic uvlo = 1'b0;
  logic grounded = 1'b0;
  logic [2:0] tcmp;
  logic [2:0] state;
  logic halt;
  logic halt_oe;
  ocos_pkg::ocos_drive_t drive;
  int fails = 0;
  int n_compared = 0;
  // Cycles after the event edge and expected {discharge, source}
  ocos_row_t rows [6] = '{'{8'h02, 2'b00}, '{8'h03, 2'b11}, '{8'h05, 2'b11},
    '{8'h06, 2'b01}, '{8'h0c, 2'b01}, '{8'h0d, 2'b00}};
  always #10 clock_i = ~clock_i;
  ocos_seq #(.SS_CYC(3), .TIMER_CYC(10)) ocos_seq_i (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .cmp_i({limit, trip, tcmp}),
    .uvlo_i(uvlo), .drive_o(drive), .preregulator_halt_o(halt),
    .preregulator_halt_oe_o(halt_oe), .state_o(state));
  ocos_tank_model ocos_tank_model_i (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .drive_i(drive),
    .grounded_i(grounded), .timer_cmp_o(tcmp));
  task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic pulse(input bit second);
    if (second) trip = 1'b1;
    else limit = 1'b1;
    tick(1);
    trip = 1'b0;
    limit = 1'b0;
  endtask
  task automatic wait_state(input logic [2:0] s);
    for (int i = 0; i < 400 && state !== s; i++) tick(1);
    chk("state", {1'b0, s}, {1'b0, state});
  endtask
  task close_out;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Watchdog far beyond the expected run
  initial begin
    #100000;
    fails++;
    close_out();
  end
  // Reset, table rows, then the awkward sequences
  initial begin
    tick(8);
    chk("reset drive", 4'h0, drive);
    chk("reset halt", 4'h0, {3'h0, halt_oe});
    reset_n_i = 1'b1;
    for (int r = 0; r < 6; r++) begin
      tick(40);
      pulse(1'b0);
      tick(rows[r].k);
      chk("pulses", {2'b0, rows[r].e}, drive[3:2]);
    end
    chk("state", 4'h0, {1'b0, state});
    tick(40);
    pulse(1'b0);
    tick(2);
    pulse(1'b0);
    tick(4);
    chk("retrig ss", 4'h1, {3'h0, drive.ss_discharge});
    tick(7);
    chk("retrig src", 4'h1, {3'h0, drive.timer_source});
    for (int r = 0; r < 100 && state !== 3'h1; r++) begin
      pulse(1'b0);
      tick(7);
    end
    tick(2);
    chk("shutdown", 4'hf, drive);
    chk("halt", 4'h1, {3'h0, halt_oe});
    wait_state(3'h2);
    tick(2);
    chk("stopped", 4'h4, {1'b0, drive[3:1]});
    uvlo = 1'b1;
    tick(6);
    uvlo = 1'b0;
    tick(6);
    chk("uvlo wait", 4'h2, {1'b0, state});
    chk("halt held", 4'h1, {3'h0, halt_oe});
    wait_state(3'h0);
    tick(6);
    chk("resumed", 4'h1, {3'h0, drive.switch_enable});
    tick(40);
    pulse(1'b1);
    tick(4);
    chk("trip", 4'h6, {1'b0, drive[3:1]});
    wait_state(3'h2);
    wait_state(3'h0);
    grounded = 1'b1;
    for (int r = 0; r < 20; r++) begin
      pulse(1'b0);
      tick(7);
    end
    chk("grounded", 4'h0, {1'b0, state});
    close_out();
  end
endmodule // tb_ocos_seq
`default_nettype wire
